// ### design/wdt_pkg.sv
// Purpose: Shared constants and types of the watchdog timer
// Assumes: AXI4-Lite register window with 8-bit byte addresses
// Notes:   Offsets are byte addresses, one 32-bit word each
package wdt_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_MASK  = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;

  // Control register layout and power-on value
  localparam logic [7:0] CTRL_RST = 8'h7A;
  localparam int         KEEP_BIT = 7;
  localparam int         SEL_MSB  = 6;
  localparam int         SEL_LSB  = 4;
  localparam int         KEY_MSB  = 3;
  localparam int         KEY_LSB  = 0;
  localparam logic [3:0] KEY_OFF  = 4'hA;

  // Status, mask and flag layouts
  localparam int         EVT_NORM    = 0;
  localparam int         EVT_SLEEP   = 1;
  localparam logic [1:0] EVT_RST     = 2'h0;
  localparam logic [1:0] MASK_RST    = 2'h0;
  localparam int         FLG_TO      = 0;
  localparam int         FLG_PDF     = 1;
  localparam int         FLG_RUN     = 2;
  localparam int         FLG_CNT_LSB = 8;

  // Divider: tap of code 000 is bit 7, a 256-count period
  localparam int          CNT_W   = 15;
  localparam logic [14:0] CNT_RST = 15'h0000;
  localparam logic [3:0]  TAP_LOW = 4'h7;

  // System clock divided by four
  localparam logic [1:0] PRE_LAST = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    CLR_NONE   = 3'b001,
    CLR_FIRST  = 3'b010,
    CLR_SECOND = 3'b100
  } clr_e;

  function automatic logic isMapped(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_MASK) || (a == OFS_FLAGS);
  endfunction

endpackage

// ### design/wdt_reg_if.sv
// Purpose: Register strobes between the bus slave and the watchdog core
// Assumes: One clock domain
// Notes:   Read data is combinational from the current address
`timescale 1ns/1ps
interface wdt_reg_if;
  logic        wrStb;
  logic [7:0]  wrAddr;
  logic [7:0]  wrData;
  logic        wrHit;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  logic        rdHit;

  modport bus  (output wrStb, wrAddr, wrData, rdAddr, input wrHit, rdData, rdHit);
  modport regs (input wrStb, wrAddr, wrData, rdAddr, output wrHit, rdData, rdHit);
endinterface

// ### design/wdt_divider.sv
// Purpose: 15-bit watchdog divider with selectable overflow tap
// Assumes: tick is a one-cycle enable at the watchdog clock rate
// Notes:   Clear wins over tick and never raises an overflow
`timescale 1ns/1ps
module wdt_divider (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Control
  input  wire logic        tick,
  input  wire logic        clr,
  input  wire logic [2:0]  tapSel,
  // Results
  output wire logic        ovf,
  output wire logic [14:0] cnt
);
  typedef struct packed {
    logic [14:0] cnt;
    logic        ovf;
  } div_s;

  div_s        st_ff;
  div_s        nxt_st;
  logic [14:0] inc;
  logic [3:0]  tap;
  logic [14:0] tapMask;

  assign tap     = wdt_pkg::TAP_LOW + {1'b0, tapSel};
  assign inc     = st_ff.cnt + 15'h0001;
  assign tapMask = ~(15'h7FFE << tap);

  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.ovf = 1'b0;
    if (clr)
    begin
      nxt_st.cnt = wdt_pkg::CNT_RST;
    end
    else if (tick)
    begin
      nxt_st.cnt = inc;
      // Falling tap bit marks the end of one period
      nxt_st.ovf = st_ff.cnt[tap] & ~inc[tap];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_ff <= '{cnt: wdt_pkg::CNT_RST, ovf: 1'b0};
    else if (ce)
      st_ff <= nxt_st;
  end

  assign ovf = st_ff.ovf;
  assign cnt = st_ff.cnt;

  AST_TAP_OVF: assert property (@(posedge clk) disable iff (srst)
    st_ff.ovf |-> ((st_ff.cnt & tapMask) == 15'h0000))
    else $error("Overflow without the selected tap wrapping");
endmodule

// ### design/wdt_axi_slave.sv
// Purpose: AXI4-Lite slave for the watchdog registers
// Assumes: One write and one read under way at a time
// Notes:   Address and data may arrive in either order
`timescale 1ns/1ps
module wdt_axi_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register side
  wdt_reg_if.bus           rb
);
  typedef struct packed {
    logic        awRdy;
    logic [7:0]  awAddr;
    logic        wRdy;
    logic [7:0]  wData;
    logic        wLane;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } axi_s;

  axi_s st_ff;
  axi_s nxt_st;
  logic wrGo;

  // Both halves held and no response pending
  assign wrGo      = !st_ff.awRdy && !st_ff.wRdy && !st_ff.bValid;
  assign rb.wrStb  = wrGo && st_ff.wLane;
  assign rb.wrAddr = st_ff.awAddr;
  assign rb.wrData = st_ff.wData;
  assign rb.rdAddr = s_axi_araddr;

  always_comb
  begin
    nxt_st = st_ff;
    if (s_axi_awvalid && st_ff.awRdy)
    begin
      nxt_st.awRdy  = 1'b0;
      nxt_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wRdy)
    begin
      nxt_st.wRdy  = 1'b0;
      nxt_st.wData = s_axi_wdata[7:0];
      nxt_st.wLane = s_axi_wstrb[0];
    end
    if (wrGo)
    begin
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = rb.wrHit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end
    if (st_ff.bValid && s_axi_bready)
    begin
      nxt_st.bValid = 1'b0;
      nxt_st.awRdy  = 1'b1;
      nxt_st.wRdy   = 1'b1;
    end
    if (s_axi_arvalid && st_ff.arRdy)
    begin
      nxt_st.arRdy  = 1'b0;
      nxt_st.rValid = 1'b1;
      nxt_st.rData  = rb.rdHit ? rb.rdData : 32'h0000_0000;
      nxt_st.rResp  = rb.rdHit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
    end
    if (st_ff.rValid && s_axi_rready)
    begin
      nxt_st.rValid = 1'b0;
      nxt_st.arRdy  = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_ff <= '{awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, default: '0};
    else if (ce)
      st_ff <= nxt_st;
  end

  assign s_axi_awready = st_ff.awRdy;
  assign s_axi_wready  = st_ff.wRdy;
  assign s_axi_bvalid  = st_ff.bValid;
  assign s_axi_bresp   = st_ff.bResp;
  assign s_axi_arready = st_ff.arRdy;
  assign s_axi_rvalid  = st_ff.rValid;
  assign s_axi_rdata   = st_ff.rData;
  assign s_axi_rresp   = st_ff.rResp;
endmodule

// ### design/mcu_watchdog_timer.sv
// Purpose: Watchdog timer of a small microcontroller
// Assumes: Core instruction strobes and power modes come from the clk domain
// Notes:   Configuration options are static inputs; pins pass two flops
//
// What this block does
// - Count source is sub clock or system clock over four, by static option.
// - Timeout select codes 000 to 111 give 256 up to 32768 counts.
// - Disabled only with option off and enable key 1010.
// - Power-on loads key 1010, select 111, idle keep bit 0.
// - Disabled watchdog makes its clear instructions no-ops; halt still sets powerdown.
// - Overflow while running resets the device and sets timeout flag.
// - Overflow in sleep or idle sets timeout, resets only PC and SP.
// - Count cleared by reset pin low, software clear or halt.
// - Static option picks single or paired clear instructions.
// - Paired clear works only when it differs from the previous one.
// - Control bit 7 keeps the system clock running in idle.
// - Count stops when its system clock source stops.
// - Halt clears count, sets powerdown flag, clears timeout flag unless an overflow comes in the same cycle.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module mcu_watchdog_timer (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Static configuration options
  input  wire logic        cfgSrcSub,
  input  wire logic        cfgWdtOn,
  input  wire logic        cfgPairedClear,
  // Pins
  input  wire logic        lowSpeedRcOsc,
  input  wire logic        extResetPinN,
  // Processor core
  input  wire logic        clearSingle,
  input  wire logic        clearFirst,
  input  wire logic        clearSecond,
  input  wire logic        haltExec,
  input  wire logic        sleepMode,
  input  wire logic        idleMode,
  // Reset requests and status
  output wire logic        deviceReset,
  output wire logic        pcSpReset,
  output wire logic        timeoutFlag,
  output wire logic        powerdownFlag,
  output wire logic        idleSysclkKeep,
  output wire logic        irq,
  // AXI4-Lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    logic [7:0]      ctrl;
    logic [1:0]      evt;
    logic [1:0]      mask;
    logic            subSync1;
    logic            subSync2;
    logic            subPrev;
    logic            pinSync1;
    logic            pinSync2;
    logic [1:0]      preCnt;
    wdt_pkg::clr_e   lastClr;
    logic            toFlag;
    logic            pdFlag;
    logic            devRst;
    logic            pcSpRst;
    logic            irq;
  } wdt_s;

  wdt_s        st_ff;
  wdt_s        nxt_st;
  wdt_reg_if   rb ();
  logic        running;
  logic        asleep;
  logic        sysStopped;
  logic        subRise;
  logic        wdTick;
  logic        firstOk;
  logic        secondOk;
  logic        swClr;
  logic        divClr;
  logic        divOvf;
  logic [14:0] divCnt;
  logic        wrCtrl;
  logic        wrStat;
  logic        wrMask;

  wdt_axi_slave u_axi (
    .clk           (clk),
    .srst          (srst),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rb            (rb)
  );

  wdt_divider u_div (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .tick   (wdTick),
    .clr    (divClr),
    .tapSel (st_ff.ctrl[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB]),
    .ovf    (divOvf),
    .cnt    (divCnt)
  );

  // Mode and clock source decode
  assign running    = cfgWdtOn || (st_ff.ctrl[wdt_pkg::KEY_MSB:wdt_pkg::KEY_LSB] != wdt_pkg::KEY_OFF);
  assign asleep     = sleepMode || idleMode;
  assign sysStopped = sleepMode || (idleMode && !st_ff.ctrl[wdt_pkg::KEEP_BIT]);
  assign subRise    = st_ff.subSync2 && !st_ff.subPrev;
  // Sysclk source advances only while the system clock would run
  assign wdTick     = running && (cfgSrcSub ? subRise
                                            : (!sysStopped && st_ff.preCnt == wdt_pkg::PRE_LAST));

  // Software clear decode
  assign firstOk  = clearFirst && (st_ff.lastClr != wdt_pkg::CLR_FIRST);
  assign secondOk = clearSecond && (st_ff.lastClr != wdt_pkg::CLR_SECOND);
  assign swClr    = running && (cfgPairedClear ? (firstOk || secondOk) : clearSingle);
  // Disabled watchdog holds its count at zero
  assign divClr   = !running || !st_ff.pinSync2 || swClr || haltExec || divOvf;

  // Register strobes
  assign rb.wrHit = wdt_pkg::isMapped(rb.wrAddr);
  assign rb.rdHit = wdt_pkg::isMapped(rb.rdAddr);
  assign wrCtrl   = rb.wrStb && (rb.wrAddr == wdt_pkg::OFS_CTRL);
  assign wrStat   = rb.wrStb && (rb.wrAddr == wdt_pkg::OFS_STAT);
  assign wrMask   = rb.wrStb && (rb.wrAddr == wdt_pkg::OFS_MASK);

  always_comb
  begin
    rb.rdData = 32'h0000_0000;
    case (rb.rdAddr)
      wdt_pkg::OFS_CTRL:
        rb.rdData[7:0] = st_ff.ctrl;
      wdt_pkg::OFS_STAT:
        rb.rdData[1:0] = st_ff.evt;
      wdt_pkg::OFS_MASK:
        rb.rdData[1:0] = st_ff.mask;
      wdt_pkg::OFS_FLAGS:
      begin
        rb.rdData[wdt_pkg::FLG_TO]  = st_ff.toFlag;
        rb.rdData[wdt_pkg::FLG_PDF] = st_ff.pdFlag;
        rb.rdData[wdt_pkg::FLG_RUN] = running;
        rb.rdData[wdt_pkg::FLG_CNT_LSB +: wdt_pkg::CNT_W] = divCnt;
      end
      default:
        rb.rdData = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt_st          = st_ff;
    // Pins: first flop feeds only the second
    nxt_st.subSync1 = lowSpeedRcOsc;
    nxt_st.subSync2 = st_ff.subSync1;
    nxt_st.subPrev  = st_ff.subSync2;
    nxt_st.pinSync1 = extResetPinN;
    nxt_st.pinSync2 = st_ff.pinSync1;
    if (!sysStopped)
    begin
      nxt_st.preCnt = st_ff.preCnt + 2'h1;
    end

    if (wrCtrl)
    begin
      nxt_st.ctrl = rb.wrData;
    end
    if (wrMask)
    begin
      nxt_st.mask = rb.wrData[1:0];
    end

    // Paired clear remembers which form last succeeded
    if (swClr && cfgPairedClear)
    begin
      unique case (st_ff.lastClr)
        wdt_pkg::CLR_NONE:   nxt_st.lastClr = firstOk ? wdt_pkg::CLR_FIRST : wdt_pkg::CLR_SECOND;
        wdt_pkg::CLR_FIRST:  nxt_st.lastClr = wdt_pkg::CLR_SECOND;
        wdt_pkg::CLR_SECOND: nxt_st.lastClr = wdt_pkg::CLR_FIRST;
        default:             nxt_st.lastClr = wdt_pkg::CLR_NONE;
      endcase
    end

    // Flags: overflow set wins over the halt clear
    if (swClr)
    begin
      nxt_st.pdFlag = 1'b0;
    end
    if (haltExec)
    begin
      nxt_st.pdFlag = 1'b1;
      nxt_st.toFlag = 1'b0;
    end
    if (divOvf)
    begin
      nxt_st.toFlag = 1'b1;
    end
    nxt_st.devRst  = divOvf && !asleep;
    nxt_st.pcSpRst = divOvf && asleep;

    // Sticky events, write one to clear, set wins
    if (wrStat)
    begin
      nxt_st.evt = st_ff.evt & ~rb.wrData[1:0];
    end
    if (divOvf)
    begin
      nxt_st.evt[asleep ? wdt_pkg::EVT_SLEEP : wdt_pkg::EVT_NORM] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.evt & nxt_st.mask);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_ff <= '{ctrl: wdt_pkg::CTRL_RST, evt: wdt_pkg::EVT_RST, mask: wdt_pkg::MASK_RST,
                 lastClr: wdt_pkg::CLR_NONE, pinSync1: 1'b1, pinSync2: 1'b1, default: '0};
    else if (ce)
      st_ff <= nxt_st;
  end

  assign deviceReset    = st_ff.devRst;
  assign pcSpReset      = st_ff.pcSpRst;
  assign timeoutFlag    = st_ff.toFlag;
  assign powerdownFlag  = st_ff.pdFlag;
  assign idleSysclkKeep = st_ff.ctrl[wdt_pkg::KEEP_BIT];
  assign irq            = st_ff.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_SYSDIV_SPACING: assert property (
    (ce && !cfgSrcSub && wdTick) |=> !wdTick)
    else $error("System clock source ticked twice in a row");

  AST_KEY_DISABLE: assert property (
    (ce && !running) |=> (divCnt == 15'h0000))
    else $error("Disabled watchdog kept counting");

  AST_POR_CTRL: assert property (
    $fell(srst) |-> (st_ff.ctrl == wdt_pkg::CTRL_RST))
    else $error("Control register not at power-on value");

  AST_DIS_NOP: assert property (
    (ce && !running && !haltExec && (clearSingle || clearFirst || clearSecond))
      |=> (powerdownFlag == $past(powerdownFlag)) && (st_ff.lastClr == $past(st_ff.lastClr)))
    else $error("Clear instruction acted while disabled");

  AST_OVF_NORM: assert property (
    (ce && divOvf && !asleep) |=> (deviceReset && timeoutFlag && !pcSpReset))
    else $error("Overflow in run did not reset the device");

  AST_OVF_SLEEP: assert property (
    (ce && divOvf && asleep) |=> (pcSpReset && timeoutFlag && !deviceReset))
    else $error("Overflow in sleep gave the wrong reset");

  AST_PIN_CLR: assert property (
    (ce && !st_ff.pinSync2) |=> (divCnt == 15'h0000))
    else $error("Reset pin did not clear the count");

  AST_SINGLE_CLR: assert property (
    (ce && running && !cfgPairedClear && clearSingle && !divOvf) |=> (divCnt == 15'h0000))
    else $error("Single clear did not clear the count");

  AST_PAIR_ALT: assert property (
    (ce && swClr && cfgPairedClear) |=> (st_ff.lastClr != $past(st_ff.lastClr)))
    else $error("Paired clear did not alternate");

  AST_KEEP_BIT: assert property (
    (ce && wrCtrl) |=> (idleSysclkKeep == $past(rb.wrData[wdt_pkg::KEEP_BIT])))
    else $error("Idle clock keep bit not taken from write");

  AST_SYS_STOP: assert property (
    (ce && !cfgSrcSub && sysStopped && !divClr) |=> $stable(divCnt))
    else $error("Count advanced with stopped system clock");

  AST_HALT: assert property (
    (ce && haltExec && !divOvf) |=> (powerdownFlag && !timeoutFlag && divCnt == 15'h0000))
    else $error("Halt did not clear count and set powerdown");
endmodule

// ### test/wdt_core_model.sv
// Purpose: Processor core issuing the watchdog instructions
// Assumes: Strobes change just after the rising clock edge
// Notes:   op 0 single clear, 1 first, 2 second, 3 halt
`timescale 1ns/1ps
module wdt_core_model (
  // Clock
  input  wire logic clk,
  // Instruction strobes
  output logic      clearSingle,
  output logic      clearFirst,
  output logic      clearSecond,
  output logic      haltExec
);
  initial {clearSingle, clearFirst, clearSecond, haltExec} = 4'h0;

  // Each instruction is exactly one cycle long
  task automatic exec(input logic [1:0] op);
    @(posedge clk);
    clearSingle <= (op == 2'h0);
    clearFirst  <= (op == 2'h1);
    clearSecond <= (op == 2'h2);
    haltExec    <= (op == 2'h3);
    @(posedge clk);
    {clearSingle, clearFirst, clearSecond, haltExec} <= 4'h0;
  endtask
endmodule

// ### test/mcu_watchdog_timer_tb_top.sv
// Purpose: Self-checking bench of the watchdog timer
// Assumes: Static options change only while reset is held
// Notes:   Select codes above 011 are only read back, their periods are too long
`timescale 1ns/1ps
module mcu_watchdog_timer_tb_top;
  logic        clk, srst, ce, cfgSrcSub, cfgWdtOn, cfgPairedClear, lowSpeedRcOsc, extResetPinN;
  logic        sleepMode, idleMode, subRun, clearSingle, clearFirst, clearSecond, haltExec;
  logic        deviceReset, pcSpReset, timeoutFlag, powerdownFlag, idleSysclkKeep, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          failures, samplesChecked, n, c1, c2;
  logic [1:0]  ops [10] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1};
  logic        lows [10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  mcu_watchdog_timer mcu_watchdog_timer_i (
    .clk, .srst, .ce, .cfgSrcSub, .cfgWdtOn, .cfgPairedClear, .lowSpeedRcOsc, .extResetPinN,
    .clearSingle, .clearFirst, .clearSecond, .haltExec, .sleepMode, .idleMode,
    .deviceReset, .pcSpReset, .timeoutFlag, .powerdownFlag, .idleSysclkKeep, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  wdt_core_model wdt_core_model_i (.clk, .clearSingle, .clearFirst, .clearSecond, .haltExec);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Sub clock of eight cycles, standing low when not in use
  initial
  begin
    lowSpeedRcOsc = 1'b0;
    forever
    begin
      repeat (4) @(posedge clk);
      lowSpeedRcOsc <= subRun & ~lowSpeedRcOsc;
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic axRd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic rdCnt(output int c);
    axRd(8'h0C);
    c = int'(rd[22:8]);
  endtask

  // Count must be near zero only when the clear was honoured
  task automatic clrChk(input logic [1:0] op, input logic low);
    int c;
    cyc(200);
    wdt_core_model_i.exec(op);
    rdCnt(c);
    chk("count after clear", {31'h0, low}, {31'h0, c < 4});
  endtask

  task automatic waitPulse(input logic pcSp, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((pcSp ? pcSpReset : deviceReset) !== 1'b1 && n < lim);
  endtask

  // Pulse to pulse, so the divider phase at entry does not matter
  task automatic period(input logic pcSp, input int p);
    waitPulse(pcSp, 3 * p);
    waitPulse(pcSp, 2 * p);
    chk("overflow period", p, n);
  endtask

  task automatic doReset(input logic sub, input logic on, input logic paired);
    srst           <= 1'b1;
    cfgSrcSub      <= sub;
    cfgWdtOn       <= on;
    cfgPairedClear <= paired;
    cyc(3);
    srst           <= 1'b0;
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    cyc(100000);
    failures++;
    giveVerdict();
  end

  initial
  begin
    failures = 0;
    samplesChecked = 0;
    ce = 1'b1;
    subRun = 1'b0;
    extResetPinN = 1'b1;
    sleepMode = 1'b0;
    idleMode = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    doReset(1'b0, 1'b0, 1'b0);
    axRd(8'h00);
    chk("control reset", 32'h7A, rd);
    chk("keep bit reset", 0, idleSysclkKeep);
    axRd(8'h0C);
    chk("flags disabled", 32'h0, rd);
    axRd(8'h10);
    chk("unmapped read", 2, rsp);
    wdt_core_model_i.exec(2'h3);
    cyc(1);
    chk("halt powerdown", 1, powerdownFlag);
    wdt_core_model_i.exec(2'h0);
    cyc(1);
    chk("disabled clear", 1, powerdownFlag);
    $display("test disabled done");
    axWr(8'h00, 32'h05);
    for (int i = 0; i < 4; i++)
      clrChk(ops[i], lows[i]);
    chk("clear drops powerdown", 0, powerdownFlag);
    $display("test single clear done");
    for (int s = 0; s < 4; s++)
    begin
      axWr(8'h00, {25'h0, s[2:0], 4'h5});
      period(1'b0, 1024 << s);
    end
    chk("timeout flag", 1, timeoutFlag);
    for (int s = 4; s < 8; s++)
    begin
      axWr(8'h00, {25'h0, s[2:0], 4'h5});
      axRd(8'h00);
      chk("select readback", {25'h0, s[2:0], 4'h5}, rd);
    end
    $display("test periods done");
    wdt_core_model_i.exec(2'h0);
    axWr(8'h04, 32'h3);
    axWr(8'h00, 32'h85);
    cyc(1);
    chk("keep output", 1, idleSysclkKeep);
    idleMode <= 1'b1;
    period(1'b1, 1024);
    idleMode <= 1'b0;
    axRd(8'h04);
    chk("status asleep only", 2, rd);
    axWr(8'h08, 32'h1);
    cyc(1);
    chk("irq masked", 0, irq);
    axWr(8'h08, 32'h2);
    cyc(1);
    chk("irq raised", 1, irq);
    axWr(8'h04, 32'h2);
    cyc(1);
    chk("irq cleared", 0, irq);
    axWr(8'h10, 32'h0);
    chk("unmapped write", 2, rsp);
    $display("test idle and irq done");
    // Frozen clock enable must hold the count, prescaler included
    rdCnt(c1);
    ce <= 1'b0;
    cyc(100);
    ce <= 1'b1;
    rdCnt(c2);
    chk("count held by ce", 1, c2 - c1 < 8);
    sleepMode <= 1'b1;
    rdCnt(c1);
    cyc(100);
    rdCnt(c2);
    chk("count frozen", c1, c2);
    sleepMode <= 1'b0;
    axWr(8'h00, 32'h05);
    idleMode <= 1'b1;
    rdCnt(c1);
    cyc(100);
    rdCnt(c2);
    chk("idle count frozen", c1, c2);
    idleMode <= 1'b0;
    extResetPinN <= 1'b0;
    cyc(20);
    rdCnt(c1);
    chk("pin holds count", 0, c1);
    extResetPinN <= 1'b1;
    // Let the count grow so that only the halt can zero it
    cyc(200);
    wdt_core_model_i.exec(2'h3);
    cyc(1);
    chk("halt timeout", 0, timeoutFlag);
    chk("halt powerdown", 1, powerdownFlag);
    rdCnt(c1);
    chk("halt count", 1, c1 < 4);
    $display("test stop, pin and halt done");
    doReset(1'b1, 1'b1, 1'b1);
    subRun <= 1'b1;
    axRd(8'h0C);
    chk("option forces run", 32'h4, {24'h0, rd[7:0]});
    for (int i = 4; i < 10; i++)
      clrChk(ops[i], lows[i]);
    $display("test paired clear done");
    axWr(8'h00, 32'h05);
    sleepMode <= 1'b1;
    period(1'b1, 2048);
    sleepMode <= 1'b0;
    $display("test sub clock done");
    giveVerdict();
  end
endmodule
